// >>> design/pec_counter_ctrl.v
`timescale 1ns/1ps
`include "pec_consts.vh"
module pec_counter_ctrl
(
   input wire i_sys_clk,
   input wire i_sys_rst,
   input wire i_msr_wr,
   input wire i_msr_rd,
   input wire [7:0] i_msr_addr,
   input wire [63:0] i_msr_wdata,
   input wire [1:0] i_cpl,
   input wire [127:0] i_ctr0_events,
   input wire [127:0] i_ctr1_events,
   output reg [63:0] o_msr_rdata,
   output reg o_msr_ack,
   output reg o_msr_err,
   output reg o_ctr0_indicator,
   output reg o_ctr1_indicator
);

   // Codes classed as durations; the class feeds only the pin path, and every code counts clocks while held
   // Every code is listed so a new event class needs only its own line changed
   function is_duration;
      input [6:0] code;
      begin
         case (code)
            // Occurrence codes shared by both counters
            7'h00: is_duration = 1'b0;
            7'h01: is_duration = 1'b0;
            7'h02: is_duration = 1'b0;
            7'h03: is_duration = 1'b0;
            7'h04: is_duration = 1'b0;
            7'h05: is_duration = 1'b0;
            7'h06: is_duration = 1'b0;
            7'h07: is_duration = 1'b0;
            7'h08: is_duration = 1'b0;
            7'h09: is_duration = 1'b0;
            7'h0A: is_duration = 1'b0;
            7'h0B: is_duration = 1'b0;
            7'h0C: is_duration = 1'b0;
            7'h0D: is_duration = 1'b0;
            7'h0E: is_duration = 1'b0;
            7'h0F: is_duration = 1'b0;
            7'h10: is_duration = 1'b0;
            7'h11: is_duration = 1'b0;
            7'h12: is_duration = 1'b0;
            7'h13: is_duration = 1'b0;
            7'h14: is_duration = 1'b0;
            7'h15: is_duration = 1'b0;
            7'h16: is_duration = 1'b0;
            7'h17: is_duration = 1'b0;

            // Bus and stall durations mixed with bus-cycle occurrences
            `PEC_DUR_18: is_duration = 1'b1;
            `PEC_DUR_19: is_duration = 1'b1;
            `PEC_DUR_1A: is_duration = 1'b1;
            `PEC_DUR_1B: is_duration = 1'b1;
            7'h1C: is_duration = 1'b0;
            7'h1D: is_duration = 1'b0;
            7'h1E: is_duration = 1'b0;
            `PEC_DUR_1F: is_duration = 1'b1;

            // Codes whose meaning may differ per counter keep one class here
            7'h20: is_duration = 1'b0;
            7'h21: is_duration = 1'b0;
            7'h22: is_duration = 1'b0;
            7'h23: is_duration = 1'b0;
            7'h24: is_duration = 1'b0;
            7'h25: is_duration = 1'b0;
            7'h26: is_duration = 1'b0;
            7'h27: is_duration = 1'b0;
            7'h28: is_duration = 1'b0;
            7'h29: is_duration = 1'b0;
            7'h2A: is_duration = 1'b0;
            7'h2B: is_duration = 1'b0;
            7'h2C: is_duration = 1'b0;
            7'h2D: is_duration = 1'b0;
            7'h2E: is_duration = 1'b0;
            7'h2F: is_duration = 1'b0;
            7'h30: is_duration = 1'b0;
            7'h31: is_duration = 1'b0;
            7'h32: is_duration = 1'b0;
            7'h33: is_duration = 1'b0;
            7'h34: is_duration = 1'b0;
            7'h35: is_duration = 1'b0;
            7'h36: is_duration = 1'b0;
            7'h37: is_duration = 1'b0;
            `PEC_DUR_38: is_duration = 1'b1;
            7'h39: is_duration = 1'b0;
            7'h3A: is_duration = 1'b0;
            `PEC_DUR_3B: is_duration = 1'b1;
            7'h3C: is_duration = 1'b1;
            7'h3D: is_duration = 1'b1;
            7'h3E: is_duration = 1'b1;
            7'h3F: is_duration = 1'b1;

            // Translation-buffer and decode occurrences
            7'h40: is_duration = 1'b0;
            7'h41: is_duration = 1'b0;
            7'h42: is_duration = 1'b0;
            7'h43: is_duration = 1'b0;
            7'h44: is_duration = 1'b0;
            7'h45: is_duration = 1'b0;
            7'h46: is_duration = 1'b0;
            7'h47: is_duration = 1'b0;
            7'h48: is_duration = 1'b0;

            // Unassigned upper codes count as occurrences
            7'h49: is_duration = 1'b0;
            7'h4A: is_duration = 1'b0;
            7'h4B: is_duration = 1'b0;
            7'h4C: is_duration = 1'b0;
            7'h4D: is_duration = 1'b0;
            7'h4E: is_duration = 1'b0;
            7'h4F: is_duration = 1'b0;
            7'h50: is_duration = 1'b0;
            7'h51: is_duration = 1'b0;
            7'h52: is_duration = 1'b0;
            7'h53: is_duration = 1'b0;
            7'h54: is_duration = 1'b0;
            7'h55: is_duration = 1'b0;
            7'h56: is_duration = 1'b0;
            7'h57: is_duration = 1'b0;
            7'h58: is_duration = 1'b0;
            7'h59: is_duration = 1'b0;
            7'h5A: is_duration = 1'b0;
            7'h5B: is_duration = 1'b0;
            7'h5C: is_duration = 1'b0;
            7'h5D: is_duration = 1'b0;
            7'h5E: is_duration = 1'b0;
            7'h5F: is_duration = 1'b0;
            7'h60: is_duration = 1'b0;
            7'h61: is_duration = 1'b0;
            7'h62: is_duration = 1'b0;
            7'h63: is_duration = 1'b0;
            7'h64: is_duration = 1'b0;
            7'h65: is_duration = 1'b0;
            7'h66: is_duration = 1'b0;
            7'h67: is_duration = 1'b0;
            7'h68: is_duration = 1'b0;
            7'h69: is_duration = 1'b0;
            7'h6A: is_duration = 1'b0;
            7'h6B: is_duration = 1'b0;
            7'h6C: is_duration = 1'b0;
            7'h6D: is_duration = 1'b0;
            7'h6E: is_duration = 1'b0;
            7'h6F: is_duration = 1'b0;
            7'h70: is_duration = 1'b0;
            7'h71: is_duration = 1'b0;
            7'h72: is_duration = 1'b0;
            7'h73: is_duration = 1'b0;
            7'h74: is_duration = 1'b0;
            7'h75: is_duration = 1'b0;
            7'h76: is_duration = 1'b0;
            7'h77: is_duration = 1'b0;
            7'h78: is_duration = 1'b0;
            7'h79: is_duration = 1'b0;
            7'h7A: is_duration = 1'b0;
            7'h7B: is_duration = 1'b0;
            7'h7C: is_duration = 1'b0;
            7'h7D: is_duration = 1'b0;
            7'h7E: is_duration = 1'b0;
            7'h7F: is_duration = 1'b0;
            default: is_duration = 1'b0;
         endcase
      end
   endfunction

   // Per-counter control fields, stored in register order
   reg [10:0] ctrl_f0;
   reg [10:0] ctrl_f1;
   reg [47:0] ctr0;
   reg [47:0] ctr1;
   wire [47:0] ctr_q [0:1];
   wire [10:0] field [0:1];
   wire [63:0] ctrl_word;

   assign field[0] = ctrl_f0;
   assign field[1] = ctrl_f1;
   assign ctr_q[0] = ctr0;
   assign ctr_q[1] = ctr1;
   // Bits 11..15 and 27..63 are reserved and read as zero
   assign ctrl_word[10:0] = ctrl_f0;
   assign ctrl_word[15:11] = 5'h00;
   assign ctrl_word[25:16] = ctrl_f1[9:0];
   assign ctrl_word[26] = ctrl_f1[10];
   assign ctrl_word[63:27] = 37'h0_0000_0000;

   wire ctrl_wr = i_msr_wr && (i_msr_addr == `PEC_ADDR_CTRL);
   wire [1:0] ctr_wr;
   assign ctr_wr[0] = i_msr_wr && (i_msr_addr == `PEC_ADDR_CTR0);
   assign ctr_wr[1] = i_msr_wr && (i_msr_addr == `PEC_ADDR_CTR1);

   always @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         ctrl_f0 <= `PEC_CTRL_RESET;
         ctrl_f1 <= `PEC_CTRL_RESET;
      end
      else if (ctrl_wr)
      begin
         ctrl_f0 <= {i_msr_wdata[`PEC_SEL_HI_POS], i_msr_wdata[9:0]};
         ctrl_f1 <= {i_msr_wdata[`PEC_SEL_HI_POS + `PEC_CTR1_OFS],
            i_msr_wdata[25:16]};
      end
   end

   wire [1:0] next_inc;
   wire [1:0] next_wrap;
   wire [1:0] next_pin;
   wire [47:0] next_ctr [0:1];

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1)
      begin : g_ctr
         wire [6:0] code = {field[g][`PEC_SEL_HI_POS], field[g][5:0]};
         wire kern_en = field[g][`PEC_KERN_EN_POS];
         wire user_en = field[g][`PEC_USER_EN_POS];
         wire clk_mode = field[g][`PEC_TYPE_POS];
         wire pin_ovf = field[g][`PEC_PIN_SEL_POS];
         wire [127:0] evs = (g == 0) ? i_ctr0_events : i_ctr1_events;
         wire evt = evs[code];
         // Privilege gate: neither bit holds, both bits ignore level
         wire priv_ok = (i_cpl == `PEC_USER_CPL) ? user_en : kern_en;
         // Clock mode turns the counter into a timer on the core clock
         assign next_inc[g] = priv_ok && (clk_mode ? 1'b1 : evt);
         assign next_wrap[g] = next_inc[g] && (&ctr_q[g]);
         assign next_ctr[g] = ctr_q[g] + 48'h0000_0000_0001;
         // With the pin select clear, duration and occurrence events alike hold the pin high on every cycle they are counted
         wire dur_gate = is_duration(code) && !clk_mode;
         wire occ_pin = next_inc[g];
         assign next_pin[g] = pin_ovf ? next_wrap[g] :
            (dur_gate ? (evt && priv_ok) : occ_pin);
      end
   endgenerate

   always @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         ctr0 <= 48'h0000_0000_0000;
         ctr1 <= 48'h0000_0000_0000;
         o_ctr0_indicator <= 1'b0;
         o_ctr1_indicator <= 1'b0;
      end
      else
      begin
         // A software write wins over an increment in the same cycle
         if (ctr_wr[0])
            ctr0 <= i_msr_wdata[47:0];
         else if (next_inc[0])
            ctr0 <= next_ctr[0];
         if (ctr_wr[1])
            ctr1 <= i_msr_wdata[47:0];
         else if (next_inc[1])
            ctr1 <= next_ctr[1];
         o_ctr0_indicator <= next_pin[0];
         o_ctr1_indicator <= next_pin[1];
      end
   end

   // Read selection is shared by reads and writes so an unmapped write errors too
   reg [63:0] rd_mux;
   reg rd_hit;
   always @*
   begin
      rd_mux = 64'h0000_0000_0000_0000;
      rd_hit = 1'b1;
      case (i_msr_addr)
         `PEC_ADDR_CTRL:
            rd_mux = ctrl_word;
         `PEC_ADDR_CTR0:
            rd_mux = {16'h0000, ctr0};
         `PEC_ADDR_CTR1:
            rd_mux = {16'h0000, ctr1};
         default:
            rd_hit = 1'b0;
      endcase
   end

   // Register access answers one cycle after the request
   always @(posedge i_sys_clk)
   begin
      if (i_sys_rst)
      begin
         o_msr_rdata <= 64'h0000_0000_0000_0000;
         o_msr_ack <= 1'b0;
         o_msr_err <= 1'b0;
      end
      else
      begin
         o_msr_ack <= i_msr_rd || i_msr_wr;
         o_msr_err <= (i_msr_rd || i_msr_wr) && !rd_hit;
         // Writes and idle cycles return zero so the data bus never leaks state
         if (i_msr_rd)
            o_msr_rdata <= rd_mux;
         else
            o_msr_rdata <= 64'h0000_0000_0000_0000;
      end
   end
endmodule // pec_counter_ctrl

// >>> shared/pec_consts.vh
`ifndef PEC_CONSTS_VH
`define PEC_CONSTS_VH
`define PEC_ADDR_W 8
`define PEC_ADDR_CTRL 8'h11
`define PEC_ADDR_CTR0 8'h12
`define PEC_ADDR_CTR1 8'h13
`define PEC_REG_W 64
`define PEC_CTR_W 48
`define PEC_SEL_W 6
`define PEC_NUM_EVT 128
`define PEC_CTR1_OFS 16
`define PEC_SEL_LO_POS 0
`define PEC_KERN_EN_POS 6
`define PEC_USER_EN_POS 7
`define PEC_TYPE_POS 8
`define PEC_PIN_SEL_POS 9
`define PEC_SEL_HI_POS 10
`define PEC_FIELD_W 11
`define PEC_CTRL_RESET 11'h000
`define PEC_USER_CPL 2'h3
`define PEC_DUR_18 7'h18
`define PEC_DUR_19 7'h19
`define PEC_DUR_1A 7'h1A
`define PEC_DUR_1B 7'h1B
`define PEC_DUR_1F 7'h1F
`define PEC_DUR_38 7'h38
`define PEC_DUR_3B 7'h3B
`define PEC_DUR_3C_BASE 5'h0F
`endif

// >>> verification/pec_counter_ctrl_monitor.sv
`timescale 1ns/1ps
module pec_counter_ctrl_monitor
(
   input wire i_sys_clk,
   input wire i_sys_rst,
   input wire i_msr_wr,
   input wire i_msr_rd,
   input wire [7:0] i_msr_addr,
   input wire [63:0] i_msr_wdata,
   input wire [63:0] o_msr_rdata,
   input wire o_msr_ack,
   input wire o_msr_err,
   input wire o_ctr0_indicator,
   input wire o_ctr1_indicator
);
   wire req = i_msr_wr | i_msr_rd;
   wire hit = i_msr_addr >= 8'h11 && i_msr_addr <= 8'h13;
   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_sys_rst);
   sequence s_wr_rd;
      i_msr_wr && i_msr_addr == 8'h11 ##1 i_msr_rd && i_msr_addr == 8'h11;
   endsequence
   a_ack_after_req: assert property (req |=> o_msr_ack) else $error("no ack");
   a_ack_only_req: assert property (!req |=> !o_msr_ack) else $error("stray ack");
   a_err_unmapped: assert property (req && !hit |=> o_msr_err) else $error("no err");
   a_err_mapped: assert property (req && hit |=> !o_msr_err) else $error("stray err");
   a_idle_data_zero: assert property (!o_msr_ack |-> o_msr_rdata == 64'h0) else $error("data");
   a_ctrl_readback: assert property (s_wr_rd |=> o_msr_rdata ==
      ($past(i_msr_wdata, 2) & 64'h0000_0000_07FF_07FF)) else $error("control readback");
   a_ctr_upper_zero: assert property (i_msr_rd && i_msr_addr != 8'h11 |=>
      o_msr_rdata[63:48] == 16'h0000) else $error("upper bits");
   a_pins_quiet_reset: assert property ($fell(i_sys_rst) |->
      !o_ctr0_indicator && !o_ctr1_indicator) else $error("pin after reset");
endmodule // pec_counter_ctrl_monitor
bind pec_counter_ctrl pec_counter_ctrl_monitor pec_counter_ctrl_monitor_i (.i_sys_clk,
   .i_sys_rst, .i_msr_wr, .i_msr_rd, .i_msr_addr, .i_msr_wdata, .o_msr_rdata, .o_msr_ack,
   .o_msr_err, .o_ctr0_indicator, .o_ctr1_indicator);

// >>> verification/pec_pin_watch.sv
`timescale 1ns/1ps
module pec_pin_watch
(
   input wire i_sys_clk,
   input wire i_pin0,
   input wire i_pin1,
   output logic [15:0] o_hits0 = 16'h0000,
   output logic [15:0] o_hits1 = 16'h0000
);
   // A probe sees only the level at each edge, so it counts high cycles
   always @(posedge i_sys_clk)
   begin
      o_hits0 <= o_hits0 + 16'(i_pin0);
      o_hits1 <= o_hits1 + 16'(i_pin1);
   end
endmodule // pec_pin_watch

// >>> verification/tb_pec_counter_ctrl.sv
`timescale 1ns/1ps
module tb_pec_counter_ctrl;
   logic i_sys_clk = 0, i_sys_rst = 1, i_msr_wr = 0, i_msr_rd = 0;
   logic [7:0] i_msr_addr = 8'h00;
   logic [63:0] i_msr_wdata = 0, o_msr_rdata, cw;
   logic [1:0] i_cpl = 0;
   logic [127:0] i_ctr0_events = 0, i_ctr1_events = 0, r, w;
   logic o_msr_ack, o_msr_err, o_ctr0_indicator, o_ctr1_indicator;
   logic [15:0] h0, h1, hb;
   logic [64:0] q[$];
   logic [6:0] c;
   logic [6:0] codes[4] = '{7'h03, 7'h18, 7'h2B, 7'h48};
   int bad_count = 0, compares = 0, n, k;
   initial forever #50 i_sys_clk = ~i_sys_clk;
   pec_counter_ctrl pec_counter_ctrl_i (.i_sys_clk, .i_sys_rst, .i_msr_wr, .i_msr_rd,
      .i_msr_addr, .i_msr_wdata, .i_cpl, .i_ctr0_events, .i_ctr1_events, .o_msr_rdata,
      .o_msr_ack, .o_msr_err, .o_ctr0_indicator, .o_ctr1_indicator);
   pec_pin_watch pec_pin_watch_i (.i_sys_clk, .i_pin0(o_ctr0_indicator),
      .i_pin1(o_ctr1_indicator), .o_hits0(h0), .o_hits1(h1));
   task chk(input logic [64:0] s, e);
      compares++;
      if (s !== e)
      begin
         bad_count++;
         $display("BAD %0t %h %h", $time, s, e);
      end
   endtask
   task print_verdict;
      $display("compares %0d bad %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Request holds until the next call, so back-to-back calls give back-to-back accesses
   task acc(input logic we, re, input logic [7:0] a, input logic [63:0] d, e);
      @(posedge i_sys_clk);
      #1 {i_msr_wr, i_msr_rd, i_msr_addr, i_msr_wdata} = {we, re, a, d};
      if (we | re)
         q.push_back({a < 8'h11 || a > 8'h13, e});
   endtask
   task pulse(input logic [127:0] v0, v1, input int cnt);
      @(posedge i_sys_clk);
      #1 {i_ctr0_events, i_ctr1_events} = {v0, v1};
      repeat (cnt) @(posedge i_sys_clk);
      #1 {i_ctr0_events, i_ctr1_events} = 0;
   endtask
   always @(posedge i_sys_clk)
      if (o_msr_ack === 1'b1)
         chk({o_msr_err, o_msr_rdata}, q.pop_front());
   initial
   begin
      repeat (2000) @(posedge i_sys_clk);
      bad_count++;
      print_verdict;
   end
   initial
   begin
      void'($urandom(80));
      repeat (6) @(posedge i_sys_clk);
      #1 i_sys_rst = 0;
      acc(0, 1, 8'h11, 0, 0);
      acc(0, 1, 8'h13, 0, 0);
      acc(0, 1, 8'h10, 0, 0);
      acc(1, 0, 8'h14, 1, 0);
      repeat (4)
      begin
         cw = {$urandom, $urandom};
         acc(1, 0, 8'h11, cw, 0);
         acc(0, 1, 8'h11, 0, cw & 64'h0000_0000_07FF_07FF);
      end
      acc(1, 0, 8'h11, 0, 0);
      $display("register map done");
      for (int j = 0; j < 8; j++)
      begin
         n = j % 2;
         c = codes[j / 2];
         acc(1, 0, 8'h12 + 8'(n), 0, 0);
         k = 1 + $urandom % 8;
         i_cpl = 2'($urandom);
         cw = 64'({c[6], 2'b00, i_cpl == 2'h3, i_cpl != 2'h3, c[5:0]}) << (16 * n);
         r = 128'h1 << c;
         w = 128'h1 << (c ^ 7'h01);
         hb = n ? h1 : h0;
         acc(1, 0, 8'h11, cw, 0);
         acc(0, 0, 0, 0, 0);
         pulse(n ? r : w, n ? w : r, 3);
         pulse(n ? 0 : r, n ? r : 0, k);
         cw = 64'({c[6], 2'b00, i_cpl != 2'h3, i_cpl == 2'h3, c[5:0]}) << (16 * n);
         acc(1, 0, 8'h11, cw, 0);
         acc(0, 0, 0, 0, 0);
         pulse(n ? 0 : r, n ? r : 0, k);
         acc(0, 1, 8'h12 + 8'(n), 0, k);
         repeat (3) acc(0, 0, 0, 0, 0);
         chk(65'(n ? h1 : h0), 65'(hb + k));
         acc(1, 0, 8'h12 + 8'(n), 64'h0000_FFFF_FFFF_FFFE, 0);
         hb = n ? h1 : h0;
         acc(1, 0, 8'h11, 64'h0000_0000_0000_03C0 << (16 * n), 0);
         repeat (8) acc(0, 0, 0, 0, 0);
         acc(1, 0, 8'h11, 0, 0);
         repeat (3) acc(0, 0, 0, 0, 0);
         chk(65'(n ? h1 : h0), 65'(hb + 1));
         $display("counter %0d code %h done", n, c);
      end
      print_verdict;
   end
endmodule // tb_pec_counter_ctrl
